//--- common/pp_defines.vh
// Port pin control logic: register offsets, field positions, reset values.
// Assumes inclusion by the design files and the bench; definitions only.
`ifndef PP_DEFINES_VH
`define PP_DEFINES_VH

`define PP_NPORT 3
`define PP_WIDTH 8

// Register byte offsets, one aligned word each
`define PP_OFF_DIR_A 12'h000
`define PP_OFF_DIR_B 12'h004
`define PP_OFF_DIR_C 12'h008
`define PP_OFF_OUT_A 12'h00c
`define PP_OFF_OUT_B 12'h010
`define PP_OFF_OUT_C 12'h014
`define PP_OFF_ALT_A 12'h018
`define PP_OFF_ALT_B 12'h01c
`define PP_OFF_ALT_C 12'h020
`define PP_OFF_PIN_A 12'h024
`define PP_OFF_PIN_B 12'h028
`define PP_OFF_PIN_C 12'h02c
`define PP_OFF_CHG_A 12'h030
`define PP_OFF_CHG_B 12'h034
`define PP_OFF_CHG_C 12'h038
`define PP_OFF_ANA_A 12'h03c
`define PP_OFF_RADIO 12'h040
`define PP_OFF_IRQ_STAT 12'h044
`define PP_OFF_IRQ_MASK 12'h048

// Field positions
`define PP_BIT_AMP_SEL 6
`define PP_BIT_ANT_SEL 7
`define PP_BIT_AMP_LINE 2
`define PP_BIT_ANT_LINE 3
`define PP_BIT_DBG_LO 6

// Interrupt status bits, one per port
`define PP_IRQ_A 0
`define PP_IRQ_B 1
`define PP_IRQ_C 2

// Reset values
`define PP_RST_DIR 8'h00
`define PP_RST_OUT 8'h00
`define PP_RST_ALT 8'h00
`define PP_RST_CHG 8'h00
`define PP_RST_ANA 8'h00
`define PP_RST_RADIO 8'h00
`define PP_RST_MASK 3'h0

// AHB transfer type
`define PP_HTRANS_NONSEQ 2'h2

`endif

//--- hw/pp_sync.v
// Two-flop synchroniser for a group of pad inputs.
// Assumes pad levels are asynchronous to mclk.
`timescale 1ns/1ps
module pp_sync (
  // Clock and reset
  input wire mclk,
  input wire sys_rst,
  // Data
  input wire [7:0] async_in,
  output reg [7:0] sync_out
);
  reg [7:0] meta_reg;

  always @(posedge mclk) begin
    if (sys_rst) begin
      meta_reg <= 8'h00;
      sync_out <= 8'h00;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule // pp_sync

//--- hw/pp_change.v
// Change detector with sticky pending flags for one port.
// Assumes a synchronised input and a one-cycle clear strobe.
`timescale 1ns/1ps
`include "pp_defines.vh"
module pp_change (
  // Clock and reset
  input wire mclk,
  input wire sys_rst,
  // Pin levels and control
  input wire [7:0] level,
  input wire [7:0] enable,
  input wire clear,
  // Status
  output reg [7:0] pending_reg
);
  reg [7:0] prev_reg;
  reg primed_reg;
  wire [7:0] changed;

  // First sample after reset is no change
  assign changed = (level ^ prev_reg) & enable & {8{primed_reg}};

  always @(posedge mclk) begin
    if (sys_rst) begin
      prev_reg <= 8'h00;
      primed_reg <= 1'b0;
      pending_reg <= 8'h00;
    end else begin
      prev_reg <= level;
      primed_reg <= 1'b1;
      // New change beats a read clear
      pending_reg <= (clear ? (pending_reg & ~enable) : pending_reg) | changed;
    end
  end
endmodule // pp_change

//--- hw/pp_port_ctrl.v
// Port pin control: direction, output source, pull-up, change interrupts
// for three 8-bit ports, analog disable on port A, radio functions on bank B.
// Assumes an AHB-Lite master, pads outside with output, enable, pull-up.
//
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "pp_defines.vh"
module pp_port_ctrl (
  // Clock and reset
  input wire mclk,
  input wire sys_rst,
  // AHB-Lite slave
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Pads, port A
  input wire [7:0] pad_a_in,
  output reg [7:0] pad_a_out,
  output reg [7:0] pad_a_oe,
  output reg [7:0] pad_a_pullup,
  // Pads, port B
  input wire [7:0] pad_b_in,
  output reg [7:0] pad_b_out,
  output reg [7:0] pad_b_oe,
  output reg [7:0] pad_b_pullup,
  // Pads, port C
  input wire [7:0] pad_c_in,
  output reg [7:0] pad_c_out,
  output reg [7:0] pad_c_oe,
  output reg [7:0] pad_c_pullup,
  // Peripheral outputs and radio functions
  input wire [7:0] periph_a_out,
  input wire [7:0] periph_b_out,
  input wire [7:0] periph_c_out,
  input wire amp_control_output,
  input wire antenna_select_output,
  // Debug
  input wire debug_enable,
  // Interrupt
  output reg irq
);
  // Control registers
  reg [7:0] dir_a_reg, dir_b_reg, dir_c_reg;
  reg [7:0] out_a_reg, out_b_reg, out_c_reg;
  reg [7:0] alt_a_reg, alt_b_reg, alt_c_reg;
  reg [7:0] chg_a_reg, chg_b_reg, chg_c_reg;
  reg [7:0] ana_a_reg;
  reg [7:0] radio_reg;
  reg [2:0] irq_stat_reg;
  reg [2:0] irq_mask_reg;
  // Bus data phase state and debug sync
  reg wr_pend_reg;
  reg [11:0] wr_addr_reg;
  reg dbg_meta_reg, dbg_reg;

  wire [7:0] sync_a, sync_b, sync_c;
  wire [7:0] pend_a, pend_b, pend_c;
  wire [7:0] view_a, view_b, view_c;
  wire rd_go, wr_go;
  wire clr_a, clr_b, clr_c, clr_stat;
  wire [2:0] irq_event;
  wire [2:0] irq_stat_next;
  wire [7:0] gpio_b_mask;
  reg [31:0] rd_data;
  reg [7:0] drv_b, oe_b;

  // Output value: peripheral or software level
  function [7:0] pick_out;
    input [7:0] alt;
    input [7:0] periph;
    input [7:0] sw;
    begin
      pick_out = (alt & periph) | (~alt & sw);
    end
  endfunction

  // Pull-up only on inputs
  function [7:0] pick_pull;
    input [7:0] dir;
    input [7:0] sw;
    begin
      pick_pull = ~dir & sw;
    end
  endfunction

  assign rd_go = hsel && hready && (htrans == `PP_HTRANS_NONSEQ) && !hwrite;
  assign wr_go = hsel && hready && (htrans == `PP_HTRANS_NONSEQ) && hwrite;
  assign clr_a = rd_go && (haddr == `PP_OFF_PIN_A);
  assign clr_b = rd_go && (haddr == `PP_OFF_PIN_B);
  assign clr_c = rd_go && (haddr == `PP_OFF_PIN_C);
  assign clr_stat = rd_go && (haddr == `PP_OFF_IRQ_STAT);

  pp_sync u_sync_a (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in(pad_a_in),
    .sync_out(sync_a)
  );
  pp_sync u_sync_b (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in(pad_b_in),
    .sync_out(sync_b)
  );
  pp_sync u_sync_c (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .async_in(pad_c_in),
    .sync_out(sync_c)
  );

  // Analog-only pins read low and trigger only when the analog bit is set or cleared while the pin is high
  assign view_a = sync_a & ~ana_a_reg;
  // Debug-owned lines read low as GPIO
  assign gpio_b_mask = dbg_reg ? 8'h3f : 8'hff;
  assign view_b = sync_b & gpio_b_mask;
  assign view_c = sync_c;

  pp_change u_chg_a (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .level(view_a),
    .enable(chg_a_reg),
    .clear(clr_a),
    .pending_reg(pend_a)
  );
  pp_change u_chg_b (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .level(view_b),
    .enable(chg_b_reg & gpio_b_mask),
    .clear(clr_b),
    .pending_reg(pend_b)
  );
  pp_change u_chg_c (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .level(view_c),
    .enable(chg_c_reg),
    .clear(clr_c),
    .pending_reg(pend_c)
  );

  assign irq_event = {|pend_c, |pend_b, |pend_a};
  // Set wins over read clear; irq follows the next status so it drops with it
  assign irq_stat_next = (clr_stat ? 3'h0 : irq_stat_reg) | irq_event;

  // Bank B with radio function overrides
  always @* begin
    drv_b = pick_out(alt_b_reg, periph_b_out, out_b_reg);
    oe_b = dir_b_reg;
    if (radio_reg[`PP_BIT_AMP_SEL] && dir_b_reg[`PP_BIT_AMP_LINE]) begin
      drv_b[`PP_BIT_AMP_LINE] = amp_control_output;
    end
    if (radio_reg[`PP_BIT_ANT_SEL] && dir_b_reg[`PP_BIT_ANT_LINE]) begin
      drv_b[`PP_BIT_ANT_LINE] = antenna_select_output;
    end
    // High impedance through the direction bit, and on the debug-owned lines 7:6
    oe_b = oe_b & gpio_b_mask;
  end

  // Read mux
  always @* begin
    rd_data = 32'h0000_0000;
    if (haddr == `PP_OFF_DIR_A) begin
      rd_data[7:0] = dir_a_reg;
    end else if (haddr == `PP_OFF_DIR_B) begin
      rd_data[7:0] = dir_b_reg;
    end else if (haddr == `PP_OFF_DIR_C) begin
      rd_data[7:0] = dir_c_reg;
    end else if (haddr == `PP_OFF_OUT_A) begin
      rd_data[7:0] = out_a_reg;
    end else if (haddr == `PP_OFF_OUT_B) begin
      rd_data[7:0] = out_b_reg;
    end else if (haddr == `PP_OFF_OUT_C) begin
      rd_data[7:0] = out_c_reg;
    end else if (haddr == `PP_OFF_ALT_A) begin
      rd_data[7:0] = alt_a_reg;
    end else if (haddr == `PP_OFF_ALT_B) begin
      rd_data[7:0] = alt_b_reg;
    end else if (haddr == `PP_OFF_ALT_C) begin
      rd_data[7:0] = alt_c_reg;
    end else if (haddr == `PP_OFF_PIN_A) begin
      rd_data[7:0] = view_a;
    end else if (haddr == `PP_OFF_PIN_B) begin
      rd_data[7:0] = view_b;
    end else if (haddr == `PP_OFF_PIN_C) begin
      rd_data[7:0] = view_c;
    end else if (haddr == `PP_OFF_CHG_A) begin
      rd_data[7:0] = chg_a_reg;
    end else if (haddr == `PP_OFF_CHG_B) begin
      rd_data[7:0] = chg_b_reg;
    end else if (haddr == `PP_OFF_CHG_C) begin
      rd_data[7:0] = chg_c_reg;
    end else if (haddr == `PP_OFF_ANA_A) begin
      rd_data[7:0] = ana_a_reg;
    end else if (haddr == `PP_OFF_RADIO) begin
      rd_data[7:0] = radio_reg;
    end else if (haddr == `PP_OFF_IRQ_STAT) begin
      rd_data[2:0] = irq_stat_reg;
    end else if (haddr == `PP_OFF_IRQ_MASK) begin
      rd_data[2:0] = irq_mask_reg;
    end
  end

  // Bus slave: zero wait states, always OKAY
  always @(posedge mclk) begin
    if (sys_rst) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_reg <= wr_go;
      if (wr_go) begin
        wr_addr_reg <= haddr;
      end
      if (rd_go) begin
        hrdata <= rd_data;
      end
    end
  end

  // Register writes in the data phase
  always @(posedge mclk) begin
    if (sys_rst) begin
      dir_a_reg <= `PP_RST_DIR;
      dir_b_reg <= `PP_RST_DIR;
      dir_c_reg <= `PP_RST_DIR;
      out_a_reg <= `PP_RST_OUT;
      out_b_reg <= `PP_RST_OUT;
      out_c_reg <= `PP_RST_OUT;
      alt_a_reg <= `PP_RST_ALT;
      alt_b_reg <= `PP_RST_ALT;
      alt_c_reg <= `PP_RST_ALT;
      chg_a_reg <= `PP_RST_CHG;
      chg_b_reg <= `PP_RST_CHG;
      chg_c_reg <= `PP_RST_CHG;
      ana_a_reg <= `PP_RST_ANA;
      radio_reg <= `PP_RST_RADIO;
      irq_mask_reg <= `PP_RST_MASK;
    end else if (wr_pend_reg) begin
      if (wr_addr_reg == `PP_OFF_DIR_A) begin
        dir_a_reg <= hwdata[7:0];
      end else if (wr_addr_reg == `PP_OFF_DIR_B) begin
        dir_b_reg <= hwdata[7:0];
      end else if (wr_addr_reg == `PP_OFF_DIR_C) begin
        dir_c_reg <= hwdata[7:0];
      end else if (wr_addr_reg == `PP_OFF_OUT_A) begin
        out_a_reg <= hwdata[7:0];
      end else if (wr_addr_reg == `PP_OFF_OUT_B) begin
        out_b_reg <= hwdata[7:0];
      end else if (wr_addr_reg == `PP_OFF_OUT_C) begin
        out_c_reg <= hwdata[7:0];
      end else if (wr_addr_reg == `PP_OFF_ALT_A) begin
        alt_a_reg <= hwdata[7:0];
      end else if (wr_addr_reg == `PP_OFF_ALT_B) begin
        alt_b_reg <= hwdata[7:0];
      end else if (wr_addr_reg == `PP_OFF_ALT_C) begin
        alt_c_reg <= hwdata[7:0];
      end else if (wr_addr_reg == `PP_OFF_CHG_A) begin
        chg_a_reg <= hwdata[7:0];
      end else if (wr_addr_reg == `PP_OFF_CHG_B) begin
        chg_b_reg <= hwdata[7:0];
      end else if (wr_addr_reg == `PP_OFF_CHG_C) begin
        chg_c_reg <= hwdata[7:0];
      end else if (wr_addr_reg == `PP_OFF_ANA_A) begin
        ana_a_reg <= hwdata[7:0];
      end else if (wr_addr_reg == `PP_OFF_RADIO) begin
        radio_reg <= hwdata[7:0];
      end else if (wr_addr_reg == `PP_OFF_IRQ_MASK) begin
        irq_mask_reg <= hwdata[2:0];
      end
    end
  end

  // Status, debug sync, pads and interrupt
  always @(posedge mclk) begin
    if (sys_rst) begin
      irq_stat_reg <= 3'h0;
      dbg_meta_reg <= 1'b0;
      dbg_reg <= 1'b0;
      irq <= 1'b0;
      pad_a_out <= 8'h00;
      pad_a_oe <= 8'h00;
      pad_a_pullup <= 8'h00;
      pad_b_out <= 8'h00;
      pad_b_oe <= 8'h00;
      pad_b_pullup <= 8'h00;
      pad_c_out <= 8'h00;
      pad_c_oe <= 8'h00;
      pad_c_pullup <= 8'h00;
    end else begin
      dbg_meta_reg <= debug_enable;
      dbg_reg <= dbg_meta_reg;
      irq_stat_reg <= irq_stat_next;
      irq <= |(irq_stat_next & irq_mask_reg);
      pad_a_out <= pick_out(alt_a_reg, periph_a_out, out_a_reg);
      pad_a_oe <= dir_a_reg;
      pad_a_pullup <= pick_pull(dir_a_reg, out_a_reg);
      pad_b_out <= drv_b;
      pad_b_oe <= oe_b;
      pad_b_pullup <= pick_pull(dir_b_reg, out_b_reg) & gpio_b_mask;
      pad_c_out <= pick_out(alt_c_reg, periph_c_out, out_c_reg);
      pad_c_oe <= dir_c_reg;
      pad_c_pullup <= pick_pull(dir_c_reg, out_c_reg);
    end
  end
endmodule // pp_port_ctrl

//--- tb/pp_pads_model.sv
// Board model: pad wires from device drive, board drive and pull-ups.
// Assumes one mclk domain; all three ports packed a, b, c low to high.
`timescale 1ns/1ps
module pp_pads_model (
  // Clock
  input wire mclk,
  // Device side
  input wire [23:0] oe,
  input wire [23:0] dout,
  input wire [23:0] pu,
  // Board side
  input wire [23:0] bd,
  input wire [23:0] ben,
  // Pad levels
  output wire [23:0] lvl
);
  reg [23:0] last_reg = 24'h000000;
  // Floating pins invert each cycle so no stale level passes for a real one
  assign lvl = (oe & dout) | (~oe & ben & bd) | (~oe & ~ben & (pu | ~last_reg));
  always @(posedge mclk) begin
    last_reg <= lvl;
  end
endmodule // pp_pads_model

//--- tb/pp_asserts.sv
// Port-level checker for the port pin controller.
// Assumes sync active-high reset and the zero-wait bus slave.
`timescale 1ns/1ps
module pp_asserts (
  input wire mclk,
  input wire sys_rst,
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire [7:0] pad_a_oe,
  input wire [7:0] pad_a_pullup,
  input wire [7:0] pad_b_oe,
  input wire [7:0] pad_b_pullup,
  input wire [7:0] pad_c_oe,
  input wire [7:0] pad_c_pullup,
  input wire debug_enable,
  input wire irq
);
  wire xfer = hsel && hready && htrans == 2'h2;
  wire wr = xfer && hwrite;
  wire rd = xfer && !hwrite;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_pullup_input_only: assert property (
    ((pad_a_oe & pad_a_pullup) | (pad_b_oe & pad_b_pullup) | (pad_c_oe & pad_c_pullup)) == 8'h00)
    else $error("pull-up on a driven pin");
  a_pads_hold_idle: assert property (
    !wr [*3] |=> $stable({pad_a_oe, pad_a_pullup, pad_c_oe, pad_c_pullup}))
    else $error("pad control moved without a write");
  a_rdata_upper_zero: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data above bit 7 not zero");
  a_rdata_stands: assert property (!rd |=> $stable(hrdata))
    else $error("read data changed without a read");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("slave not ready or not okay");
  a_reset_clears: assert property (
    $fell(sys_rst) |-> !irq && {pad_a_oe, pad_b_oe, pad_c_oe} == 24'h000000)
    else $error("outputs not cleared by reset");
  a_irq_fall_cause: assert property (
    $fell(irq) |-> $past(xfer) || $past(xfer, 2) || $past(xfer, 3) || $past(xfer, 4))
    else $error("interrupt dropped without a bus access");
  a_debug_frees: assert property (
    debug_enable [*4] |-> pad_b_oe[7:6] == 2'b00 && pad_b_pullup[7:6] == 2'b00)
    else $error("debug lines still driven");
  c_irq: cover property ($rose(irq));
  c_read: cover property (rd ##[1:4] wr);
  c_debug: cover property (debug_enable [*4]);
endmodule // pp_asserts
bind pp_port_ctrl pp_asserts u_chk (.mclk, .sys_rst, .hsel, .htrans, .hwrite, .hready,
  .hrdata, .hreadyout, .hresp, .pad_a_oe, .pad_a_pullup, .pad_b_oe, .pad_b_pullup,
  .pad_c_oe, .pad_c_pullup, .debug_enable, .irq);

//--- tb/pp_port_ctrl_tb.sv
// Self-checking bench: AHB-Lite master tasks, board model, scenario tasks.
// Assumes the shared offsets header on the include path.
`timescale 1ns/1ps
`include "pp_defines.vh"
module pp_port_ctrl_tb;
  reg mclk = 1'b0;
  reg sys_rst = 1'b1;
  reg hsel = 1'b0;
  reg [11:0] haddr = 12'h000;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg [23:0] periph = 24'h0;
  reg [23:0] bd = 24'h0;
  reg [23:0] ben = 24'hffff00;
  reg amp = 1'b0;
  reg ant = 1'b0;
  reg dbg = 1'b0;
  wire [31:0] hrdata;
  wire hreadyout;
  wire hresp;
  wire irq;
  wire [23:0] oe;
  wire [23:0] dout;
  wire [23:0] pu;
  wire [23:0] lvl;
  integer miscompares = 0;
  integer samples_checked = 0;
  integer i;
  reg [31:0] rd;
  initial begin
    forever #25 mclk = ~mclk;
  end
  pp_port_ctrl dut (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pad_a_in(lvl[7:0]), .pad_a_out(dout[7:0]), .pad_a_oe(oe[7:0]), .pad_a_pullup(pu[7:0]),
    .pad_b_in(lvl[15:8]), .pad_b_out(dout[15:8]), .pad_b_oe(oe[15:8]),
    .pad_b_pullup(pu[15:8]), .pad_c_in(lvl[23:16]), .pad_c_out(dout[23:16]),
    .pad_c_oe(oe[23:16]), .pad_c_pullup(pu[23:16]), .periph_a_out(periph[7:0]),
    .periph_b_out(periph[15:8]), .periph_c_out(periph[23:16]), .amp_control_output(amp),
    .antenna_select_output(ant), .debug_enable(dbg), .irq(irq));
  pp_pads_model board (.mclk(mclk), .oe(oe), .dout(dout), .pu(pu), .bd(bd), .ben(ben),
    .lvl(lvl));
  task final_report;
    begin
      if (miscompares == 0 && samples_checked > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("MISMATCH %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge mclk);
    end
  endtask
  // Bounded wait for a high bit; running out ends the run
  task wait_hi(input integer lim, input integer sel);
    integer k;
    begin
      k = 0;
      @(posedge mclk);
      while ((sel ? irq : hreadyout) !== 1'b1) begin
        k = k + 1;
        if (k > lim) begin
          miscompares = miscompares + 1;
          final_report;
        end
        @(posedge mclk);
      end
    end
  endtask
  task bus(input [11:0] a, input w, input [31:0] d);
    begin
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= `PP_HTRANS_NONSEQ;
      wait_hi(50, 0);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_hi(50, 0);
      rd = hrdata;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    begin
      bus(a, 1'b1, d);
    end
  endtask
  task rdc(input [11:0] a, input [31:0] exp);
    begin
      bus(a, 1'b0, 32'h0);
      chk(rd, exp);
    end
  endtask
  task t_reset_values;
    begin
      for (i = 0; i < 19; i = i + 1) begin
        if (i < 9 || i > 11) rdc(i * 4, 32'h0);
      end
      wr(12'h100, 32'hff);
      rdc(12'h100, 32'h0);
      chk(oe, 24'h0);
    end
  endtask
  task t_drive;
    begin
      wr(`PP_OFF_DIR_A, 32'h0f);
      wr(`PP_OFF_OUT_A, 32'ha5);
      wr(`PP_OFF_ALT_A, 32'h03);
      periph[7:0] <= 8'h02;
      ben[7:4] <= 4'hf;
      bd[7:4] <= 4'h3;
      cyc(3);
      chk(oe[7:0], 8'h0f);
      chk(pu[7:0], 8'ha0);
      chk(dout[3:0], 4'h6);
      periph[7:0] <= 8'h01;
      cyc(3);
      chk(dout[1:0], 2'b01);
      rdc(`PP_OFF_PIN_A, 32'h35);
      wr(`PP_OFF_ANA_A, 32'hf0);
      rdc(`PP_OFF_PIN_A, 32'h05);
    end
  endtask
  task t_change;
    begin
      wr(`PP_OFF_CHG_B, 32'h01);
      wr(`PP_OFF_IRQ_MASK, 32'h2);
      bd[8] <= 1'b1;
      wait_hi(20, 1);
      cyc(5);
      chk(irq, 1'b1);
      rdc(`PP_OFF_IRQ_STAT, 32'h2);
      rdc(`PP_OFF_PIN_B, 32'h01);
      rdc(`PP_OFF_IRQ_STAT, 32'h2);
      rdc(`PP_OFF_IRQ_STAT, 32'h0);
      cyc(3);
      chk(irq, 1'b0);
      wr(`PP_OFF_IRQ_MASK, 32'h0);
      bd[8] <= 1'b0;
      cyc(6);
      chk(irq, 1'b0);
      rdc(`PP_OFF_PIN_B, 32'h00);
      rdc(`PP_OFF_IRQ_STAT, 32'h2);
      rdc(`PP_OFF_IRQ_STAT, 32'h0);
      bd[9] <= 1'b1;
      cyc(6);
      rdc(`PP_OFF_IRQ_STAT, 32'h0);
    end
  endtask
  task t_radio;
    begin
      wr(`PP_OFF_DIR_B, 32'h0c);
      wr(`PP_OFF_RADIO, 32'hc0);
      amp <= 1'b1;
      cyc(3);
      chk(dout[11:10], 2'b01);
      amp <= 1'b0;
      ant <= 1'b1;
      cyc(3);
      chk(dout[11:10], 2'b10);
      wr(`PP_OFF_RADIO, 32'h40);
      cyc(2);
      chk(dout[11], 1'b0);
      // High impedance goes through the direction bit
      wr(`PP_OFF_DIR_B, 32'h00);
      cyc(2);
      chk(oe[11:10], 2'b00);
    end
  endtask
  task t_debug_reset;
    begin
      wr(`PP_OFF_DIR_B, 32'hc0);
      wr(`PP_OFF_DIR_C, 32'hff);
      wr(`PP_OFF_OUT_C, 32'h5a);
      wr(`PP_OFF_ALT_C, 32'h0f);
      periph[23:16] <= 8'h05;
      cyc(2);
      chk(dout[23:16], 8'h55);
      cyc(2);
      chk(oe[23:14], 10'h3ff);
      dbg <= 1'b1;
      cyc(5);
      chk(oe[15:14], 2'b00);
      dbg <= 1'b0;
      cyc(5);
      chk(oe[15:14], 2'b11);
      sys_rst <= 1'b1;
      cyc(6);
      sys_rst <= 1'b0;
      rdc(`PP_OFF_DIR_C, 32'h0);
      chk(dout, 24'h0);
      chk(oe, 24'h0);
    end
  endtask
  initial begin
    cyc(6);
    sys_rst <= 1'b0;
    t_reset_values;
    t_drive;
    t_change;
    t_radio;
    t_debug_reset;
    final_report;
  end
endmodule // pp_port_ctrl_tb
